//--- rtl/stcd_pkg.sv
package stcd_pkg;
  // Clock and derived rates
  localparam int CLK_HZ = 20_000_000;
  localparam int SYS_CLK_HZ = 5_000_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int SYS_DIV = CLK_HZ / SYS_CLK_HZ;
  // Single-shot lengths, as times and as cycle counts
  localparam int INTENSITY_NS = 350;
  localparam int COL_PULSE_NS = 100;
  localparam int STEP_PULSE_NS = 100;
  localparam int SCOPE_DELAY_NS = 1200;
  localparam int INTENSITY_CYC = (INTENSITY_NS / CLK_PERIOD_NS < 1) ? 1 :
                                 INTENSITY_NS / CLK_PERIOD_NS;
  localparam int COL_PULSE_CYC = (COL_PULSE_NS / CLK_PERIOD_NS < 1) ? 1 :
                                 COL_PULSE_NS / CLK_PERIOD_NS;
  localparam int STEP_PULSE_CYC = (STEP_PULSE_NS / CLK_PERIOD_NS < 1) ? 1 :
                                  STEP_PULSE_NS / CLK_PERIOD_NS;
  localparam int SCOPE_DELAY_CYC = (SCOPE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Counter presets and decodes
  localparam logic [3:0] BIT_PRESET = 4'hc;
  localparam logic [3:0] COL_PRESET = 4'hf;
  localparam logic [3:0] BIT_LOAD = 4'h2;
  localparam logic [3:0] BIT_DEFL = 4'h7;
  localparam logic [3:0] BIT_LAST = 4'hb;
  localparam logic [3:0] COL_FIRST = 4'h0;
  localparam logic [3:0] COL_SIX = 4'h5;
  // Character code classes
  localparam logic [6:0] CODE_SPACE = 7'h20;
  localparam logic [6:0] CODE_CTRL_MAX = 7'h1f;
  localparam logic [1:0] CODE_LOWER = 2'h3;
  // Register map (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_WORD = 8'h04;
  localparam logic [7:0] REG_GO = 8'h08;
  localparam logic [7:0] REG_DELAY = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam int CTRL_INIT_BIT = 0;
  localparam int CTRL_SO_BIT = 1;
  localparam int GO_BIT = 0;
  localparam logic [7:0] DELAY_RESET = 8'(SCOPE_DELAY_CYC);
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- rtl/stcd_oneshot.sv
`timescale 1ns/1ps
module stcd_oneshot #(
  parameter int W = 8
) (
  input wire logic clk_in, // system clock
  input wire logic srst_in, // sync reset, high
  input wire logic start_in, // trigger, retriggers
  input wire logic [W-1:0] len_in, // length in cycles, at least 1
  output logic active_out, // high while running
  output logic done_out // one-cycle pulse at expiry
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic active;
    logic done;
  } stcd_os_t;

  stcd_os_t s_r, s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (start_in) begin
      s_nxt.cnt = len_in;
      s_nxt.active = 1'b1;
    end else if (s_r.cnt != '0) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
      if (s_r.cnt == W'(1)) begin
        s_nxt.active = 1'b0;
        s_nxt.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign active_out = s_r.active;
  assign done_out = s_r.done;
endmodule

//--- rtl/stcd_top.sv
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module stcd_top
  import stcd_pkg::*;
(
  input wire logic clk_in, // 20 MHz clock
  input wire logic srst_in, // sync reset, high
  input wire logic [7:0] s_axi_awaddr_in, // AXI write address
  input wire logic s_axi_awvalid_in, // AXI write address valid
  output logic s_axi_awready_out, // AXI write address ready
  input wire logic [31:0] s_axi_wdata_in, // AXI write data
  input wire logic [3:0] s_axi_wstrb_in, // AXI write strobes
  input wire logic s_axi_wvalid_in, // AXI write data valid
  output logic s_axi_wready_out, // AXI write data ready
  output logic [1:0] s_axi_bresp_out, // AXI write response
  output logic s_axi_bvalid_out, // AXI write response valid
  input wire logic s_axi_bready_in, // AXI write response ready
  input wire logic [7:0] s_axi_araddr_in, // AXI read address
  input wire logic s_axi_arvalid_in, // AXI read address valid
  output logic s_axi_arready_out, // AXI read address ready
  output logic [31:0] s_axi_rdata_out, // AXI read data
  output logic [1:0] s_axi_rresp_out, // AXI read response
  output logic s_axi_rvalid_out, // AXI read data valid
  input wire logic s_axi_rready_in, // AXI read data ready
  input wire logic beam_in_view_in, // beam in visible area, async
  input wire logic [7:0] rom_col_in, // glyph column data
  output logic [6:0] rom_addr_out, // selected character code
  output logic [3:0] rom_col_out, // column counter
  output logic crt_intensity_n_out, // intensity to monitor, low
  output logic x_step_out, // beam X step pulse
  output logic y_ramp_up_out, // Y ramp up level
  output logic deflection_done_out, // one-cycle pulse
  output logic column_advance_out, // 100 ns column pulse
  output logic char_done_out, // one-cycle pulse
  output logic shift_mode_line_0_out, // shift mode line 0
  output logic shift_mode_line_1_out // shift mode line 1
);
  typedef struct packed {
    logic [1:0] div;
    logic char_clock, go, sync, run, dir, ramp, unblank, descend, lor, sel;
    logic [3:0] bitcnt, col;
    logic [6:0] code_lo, code_hi;
    logic [7:0] shreg;
    logic shift_out;
    logic [7:0] delay;
    logic beam_s1, beam_s2, intens_n, mode0, mode1, defl_done, char_done;
    logic [6:0] rom_addr;
    logic [3:0] rom_col;
    logic aw_got, w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready, wready, bvalid;
    logic [1:0] bresp;
    logic arready, rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } stcd_state_t;

  stcd_state_t s_r, s_nxt;

  logic int_start, colp_start, scope_start, step_start;
  logic int_active, colp_active, step_active, scope_done;

  ////////////////////////////////////////////////////////////////////////////
  // Single shots, all counted on the 20 MHz clock
  stcd_oneshot #(.W(8)) u_intensity (
    .clk_in(clk_in), .srst_in(srst_in), .start_in(int_start),
    .len_in(8'(INTENSITY_CYC)), .active_out(int_active), .done_out()
  );

  stcd_oneshot #(.W(8)) u_colpulse (
    .clk_in(clk_in), .srst_in(srst_in), .start_in(colp_start),
    .len_in(8'(COL_PULSE_CYC)), .active_out(colp_active), .done_out()
  );

  stcd_oneshot #(.W(8)) u_scope (
    .clk_in(clk_in), .srst_in(srst_in), .start_in(scope_start),
    .len_in(s_r.delay), .active_out(), .done_out(scope_done)
  );

  stcd_oneshot #(.W(8)) u_step (
    .clk_in(clk_in), .srst_in(srst_in), .start_in(step_start),
    .len_in(8'(STEP_PULSE_CYC)), .active_out(step_active), .done_out()
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic ce_sys, dot_lead, dot_trail, cclk_fall;
    logic init_req, go_req, print_allowed, char_done, eoc, serial_bit;
    logic [6:0] code;
    logic [3:0] cnt_inc;
    logic [7:0] addr;
    ce_sys = 1'b0;
    dot_lead = 1'b0;
    dot_trail = 1'b0;
    cclk_fall = 1'b0;
    init_req = 1'b0;
    go_req = 1'b0;
    print_allowed = 1'b0;
    char_done = 1'b0;
    eoc = 1'b0;
    serial_bit = 1'b0;
    code = '0;
    cnt_inc = '0;
    addr = '0;
    int_start = 1'b0;
    colp_start = 1'b0;
    scope_start = 1'b0;
    step_start = 1'b0;

    s_nxt = s_r;
    s_nxt.defl_done = 1'b0;
    s_nxt.char_done = 1'b0;
    s_nxt.beam_s1 = beam_in_view_in;
    s_nxt.beam_s2 = s_r.beam_s1;

    // 5 MHz system tick, then 2.5 MHz character clock by toggling
    ce_sys = (s_r.div == 2'(SYS_DIV - 1));
    s_nxt.div = ce_sys ? 2'h0 : s_r.div + 2'h1;
    if (ce_sys) begin
      s_nxt.char_clock = ~s_r.char_clock;
    end
    cclk_fall = ce_sys & s_r.char_clock;
    dot_lead = ce_sys & ~s_r.char_clock & s_r.run;
    dot_trail = cclk_fall & s_r.run;

    code = s_r.sel ? s_r.code_hi : s_r.code_lo;
    print_allowed = (code != CODE_SPACE) &&
                    !((code <= CODE_CTRL_MAX) && !s_r.shift_out);

    // AXI4-Lite write channel: address and data in either order
    if (s_axi_awvalid_in && s_r.awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_r.wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = s_axi_wdata_in;
      s_nxt.wstrb = s_axi_wstrb_in;
    end
    if (s_r.bvalid && s_axi_bready_in) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = RESP_OKAY;
      unique case (s_r.awaddr)
        REG_CTRL: begin
          if (s_r.wstrb[0]) begin
            init_req = s_r.wdata[CTRL_INIT_BIT];
            s_nxt.shift_out = s_r.wdata[CTRL_SO_BIT];
          end
        end
        REG_WORD: begin
          if (s_r.wstrb[0]) begin
            s_nxt.code_lo = s_r.wdata[6:0];
          end
          if (s_r.wstrb[1]) begin
            s_nxt.code_hi = s_r.wdata[14:8];
          end
        end
        REG_GO: begin
          go_req = s_r.wstrb[0] & s_r.wdata[GO_BIT];
        end
        REG_DELAY: begin
          if (s_r.wstrb[0] && s_r.wdata[7:0] != 8'h00) begin
            s_nxt.delay = s_r.wdata[7:0];
          end
        end
        REG_STATUS: begin
        end
        default: begin
          s_nxt.bresp = RESP_SLVERR;
        end
      endcase
    end
    s_nxt.awready = ~s_nxt.aw_got & ~s_nxt.bvalid;
    s_nxt.wready = ~s_nxt.w_got & ~s_nxt.bvalid;

    // AXI4-Lite read channel
    if (s_r.rvalid && s_axi_rready_in) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid_in && s_r.arready) begin
      addr = s_axi_araddr_in;
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = RESP_OKAY;
      s_nxt.rdata = '0;
      unique case (addr)
        REG_CTRL: s_nxt.rdata[CTRL_SO_BIT] = s_r.shift_out;
        REG_WORD: s_nxt.rdata = {17'h0, s_r.code_hi, 1'b0, s_r.code_lo};
        REG_GO: s_nxt.rdata[GO_BIT] = s_r.go;
        REG_DELAY: s_nxt.rdata = {24'h0, s_r.delay};
        REG_STATUS: begin
          s_nxt.rdata = {15'h0, print_allowed, s_r.col, s_r.bitcnt, s_r.sel,
                         s_r.descend, s_r.unblank, s_r.ramp, s_r.dir, s_r.run,
                         s_r.sync, s_r.go};
        end
        default: s_nxt.rresp = RESP_SLVERR;
      endcase
    end
    s_nxt.arready = ~s_nxt.rvalid;

    // Synchronise go to the falling character clock
    if (cclk_fall) begin
      if (s_r.sync) begin
        s_nxt.run = 1'b1;
        s_nxt.sync = 1'b0;
      end else if (s_r.go && !s_r.run) begin
        s_nxt.sync = 1'b1;
        s_nxt.go = 1'b0;
        s_nxt.dir = 1'b0;
        s_nxt.col = COL_FIRST;
        scope_start = 1'b1;
      end
    end

    // A print request counts only if its code may print; set wins over sync clear
    if (go_req && print_allowed) begin
      s_nxt.go = 1'b1;
    end

    // Dot clock leading edge: count, load or shift
    if (dot_lead) begin
      cnt_inc = s_r.bitcnt + 4'h1;
      s_nxt.bitcnt = cnt_inc;
      if (s_r.lor) begin
        s_nxt.shreg = rom_col_in;
      end else if (s_r.dir) begin
        s_nxt.shreg = {s_r.shreg[6:0], 1'b0};
      end else begin
        s_nxt.shreg = {1'b0, s_r.shreg[7:1]};
      end
      s_nxt.lor = (cnt_inc == BIT_LOAD);
      // Unblank as the column loads so its first dot shows; lower case skips column one
      if (s_r.lor && (code[6:5] != CODE_LOWER || s_r.col != COL_FIRST)) begin
        s_nxt.unblank = 1'b1;
      end
      if (cnt_inc == BIT_DEFL) begin
        s_nxt.defl_done = 1'b1;
        scope_start = 1'b1;
      end
      if (cnt_inc == BIT_LAST) begin
        colp_start = 1'b1;
      end
    end

    // Column advance and bit counter clear share one pulse
    if (colp_start) begin
      s_nxt.bitcnt = 4'h0;
      s_nxt.col = s_r.col + 4'h1;
      s_nxt.dir = ~s_r.dir;
      char_done = (s_r.col == COL_SIX);
    end

    // Dot clock trailing edge: send the dot at the output end
    serial_bit = s_r.dir ? s_r.shreg[7] : s_r.shreg[0];
    if (dot_trail && serial_bit && s_r.unblank && s_r.beam_s2) begin
      int_start = 1'b1;
    end

    // Scope delay expiry: step X and reverse the vertical sweep
    if (scope_done) begin
      step_start = 1'b1;
      s_nxt.ramp = ~s_r.ramp;
    end

    // End-of-character housekeeping
    eoc = char_done | init_req;
    if (eoc) begin
      s_nxt.run = 1'b0;
      s_nxt.ramp = 1'b0;
      s_nxt.descend = 1'b0;
      s_nxt.unblank = 1'b0;
      s_nxt.shreg = 8'h00;
      s_nxt.bitcnt = BIT_PRESET;
      s_nxt.col = COL_PRESET;
      s_nxt.lor = 1'b0;
    end
    if (char_done) begin
      s_nxt.char_done = 1'b1;
      s_nxt.sel = ~s_r.sel;
    end
    if (init_req) begin
      s_nxt.go = 1'b0;
      s_nxt.sync = 1'b0;
      s_nxt.sel = 1'b0;
    end

    // Registered copies feeding the pins
    s_nxt.mode0 = s_nxt.lor | ~s_nxt.dir;
    s_nxt.mode1 = s_nxt.lor | s_nxt.dir;
    s_nxt.intens_n = ~int_active;
    s_nxt.rom_addr = s_nxt.sel ? s_nxt.code_hi : s_nxt.code_lo;
    s_nxt.rom_col = s_nxt.col;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s_r <= '0;
      s_r.bitcnt <= BIT_PRESET;
      s_r.col <= COL_PRESET;
      s_r.delay <= DELAY_RESET;
      s_r.intens_n <= 1'b1;
      s_r.mode0 <= 1'b1;
      s_r.rom_col <= COL_PRESET;
      s_r.awready <= 1'b1;
      s_r.wready <= 1'b1;
      s_r.arready <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign s_axi_awready_out = s_r.awready;
  assign s_axi_wready_out = s_r.wready;
  assign s_axi_bresp_out = s_r.bresp;
  assign s_axi_bvalid_out = s_r.bvalid;
  assign s_axi_arready_out = s_r.arready;
  assign s_axi_rdata_out = s_r.rdata;
  assign s_axi_rresp_out = s_r.rresp;
  assign s_axi_rvalid_out = s_r.rvalid;
  assign rom_addr_out = s_r.rom_addr;
  assign rom_col_out = s_r.rom_col;
  assign crt_intensity_n_out = s_r.intens_n;
  assign x_step_out = step_active;
  assign y_ramp_up_out = s_r.ramp;
  assign deflection_done_out = s_r.defl_done;
  assign column_advance_out = colp_active;
  assign char_done_out = s_r.char_done;
  assign shift_mode_line_0_out = s_r.mode0;
  assign shift_mode_line_1_out = s_r.mode1;
endmodule

//--- bench/stcd_checker_sva.sv
`timescale 1ns/1ps
module stcd_checker
  import stcd_pkg::*;
(
  input wire logic clk_in, // clock
  input wire logic srst_in, // reset
  input wire logic [1:0] s_axi_bresp_out, // write resp
  input wire logic s_axi_bvalid_out, // resp valid
  input wire logic s_axi_bready_in, // resp ready
  input wire logic [3:0] rom_col_out, // column
  input wire logic crt_intensity_n_out, // dot, low
  input wire logic x_step_out, // X step
  input wire logic y_ramp_up_out, // ramp
  input wire logic deflection_done_out, // count 7
  input wire logic column_advance_out, // count 11
  input wire logic char_done_out, // done
  input wire logic shift_mode_line_0_out, // mode 0
  input wire logic shift_mode_line_1_out // mode 1
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);

  a_dot_width: assert property ($fell(crt_intensity_n_out) |->
    (!crt_intensity_n_out)[*7] ##1 crt_intensity_n_out) else $error("intensity width");
  a_col_width: assert property ($rose(column_advance_out) |->
    ##1 column_advance_out ##1 !column_advance_out) else $error("column pulse width");
  a_step_width: assert property ($rose(x_step_out) |->
    ##1 x_step_out ##1 !x_step_out) else $error("x step width");
  a_defl_pulse: assert property (deflection_done_out |=> !deflection_done_out)
    else $error("deflection pulse too long");
  a_col_order: assert property ($changed(rom_col_out) |->
    rom_col_out == $past(rom_col_out) + 4'h1 || rom_col_out == COL_PRESET)
    else $error("column skipped");
  // Stable column skips the change cycle; counter and direction flop update in the same cycle
  a_dir_right: assert property ($stable(rom_col_out) && rom_col_out inside {4'h0, 4'h2, 4'h4}
    && !(shift_mode_line_0_out && shift_mode_line_1_out) |->
    shift_mode_line_0_out && !shift_mode_line_1_out) else $error("odd column not right");
  a_dir_left: assert property ($stable(rom_col_out) && rom_col_out inside {4'h1, 4'h3, 4'h5}
    && !(shift_mode_line_0_out && shift_mode_line_1_out) |->
    !shift_mode_line_0_out && shift_mode_line_1_out) else $error("even column not left");
  a_done_clean: assert property ($rose(char_done_out) |-> ##[0:1]
    (rom_col_out == COL_PRESET && !y_ramp_up_out)) else $error("end of char not clean");
  a_idle_dark: assert property ((rom_col_out == COL_PRESET)[*8] |=> crt_intensity_n_out)
    else $error("intensity while idle");
  a_bresp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
    s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write response dropped");

  c_done: cover property ($rose(char_done_out));
  c_dot: cover property ($fell(crt_intensity_n_out));
  c_slverr: cover property (s_axi_bvalid_out && s_axi_bresp_out == RESP_SLVERR);
endmodule

bind stcd_top stcd_checker u_chk (
  .clk_in(clk_in), .srst_in(srst_in), .s_axi_bresp_out(s_axi_bresp_out),
  .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
  .rom_col_out(rom_col_out), .crt_intensity_n_out(crt_intensity_n_out),
  .x_step_out(x_step_out), .y_ramp_up_out(y_ramp_up_out),
  .deflection_done_out(deflection_done_out), .column_advance_out(column_advance_out),
  .char_done_out(char_done_out), .shift_mode_line_0_out(shift_mode_line_0_out),
  .shift_mode_line_1_out(shift_mode_line_1_out)
);

//--- bench/stcd_crt_model.sv
`timescale 1ns/1ps
module stcd_crt_model (
  input wire logic clk_in, // clock
  input wire logic clr_in, // clear tallies
  input wire logic view_en_in, // beam placed on screen
  input wire logic crt_intensity_n_in, // dot, low
  input wire logic x_step_in, // X step
  output logic beam_in_view_out, // beam visible
  output logic [15:0] dots_out, // dots seen
  output logic [15:0] steps_out // X steps seen
);
  logic int_q = 1'b1;
  logic step_q = 1'b0;
  // Off screen the edge input stays low, so no dot may pass
  assign beam_in_view_out = view_en_in;
  always @(posedge clk_in) begin
    int_q <= crt_intensity_n_in;
    step_q <= x_step_in;
    if (clr_in) begin
      dots_out <= 16'h0;
      steps_out <= 16'h0;
    end else begin
      if (int_q && !crt_intensity_n_in) dots_out <= dots_out + 16'h1;
      if (!step_q && x_step_in) steps_out <= steps_out + 16'h1;
    end
  end
endmodule

//--- bench/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import stcd_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, rom = 8'h00;
  logic [31:0] wdata = 32'h0, rd, rdata, lf = 32'h56ef;
  logic view_en = 1'b1, clr = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, view, int_n, xstep, ramp;
  logic defl, coladv, done, m0, m1;
  logic [1:0] bresp, rresp, rs;
  logic [6:0] rom_addr, lo, hi;
  logic [3:0] col;
  logic [15:0] dots, steps;
  logic [7:0] tab [6] = '{8'h20, 8'h05, 8'h85, 8'h9f, 8'h41, 8'h00};
  int n_fail = 0, n_tests = 0, cyc = 0, last_d = -1000;

  always #25 clk = ~clk;

  stcd_top DUT (
    .clk_in(clk), .srst_in(srst), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .beam_in_view_in(view), .rom_col_in(rom), .rom_addr_out(rom_addr), .rom_col_out(col),
    .crt_intensity_n_out(int_n), .x_step_out(xstep), .y_ramp_up_out(ramp),
    .deflection_done_out(defl), .column_advance_out(coladv), .char_done_out(done),
    .shift_mode_line_0_out(m0), .shift_mode_line_1_out(m1)
  );
  stcd_crt_model crt (
    .clk_in(clk), .clr_in(clr), .view_en_in(view_en), .crt_intensity_n_in(int_n),
    .x_step_in(xstep), .beam_in_view_out(view), .dots_out(dots), .steps_out(steps)
  );

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic prints(input logic [6:0] cd, input logic so);
    return cd != CODE_SPACE && (cd > CODE_CTRL_MAX || so);
  endfunction
  // Lower case shows no dots in its first column
  function automatic logic [15:0] exp_dots(input logic [6:0] cd, input logic [7:0] v);
    if (!view_en) return 16'h0;
    if (cd[6:5] == CODE_LOWER) return 16'h5 * 16'($countones(v));
    return 16'h6 * 16'($countones(v));
  endfunction

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_tests++;
    if (got !== ex) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        rs = bresp;
        break;
      end
    end
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        rd = rdata;
        rs = rresp;
        break;
      end
    end
  endtask
  task automatic run_char(input logic [6:0] cd, input logic sel);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    axw(REG_GO, 32'h1);
    do @(posedge clk); while (done !== 1'b1);
    repeat (20) @(posedge clk);
    if (cd[6:5] == CODE_LOWER) chk("lower dots", exp_dots(cd, rom), dots);
    else chk("dots", exp_dots(cd, rom), dots);
    chk("x steps", 7, steps);
    axr(REG_STATUS);
    chk("idle status", {16'h0, 8'hfc, sel, 7'h0}, rd & 32'h0000ffb7);
    chk("rom addr", sel ? hi : lo, rom_addr);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (defl === 1'b1) begin
      if (last_d >= 0) chk("dot gap", 88, cyc - last_d);
      last_d <= cyc;
    end
    // Gap is measured within one character only
    if (done === 1'b1) last_d <= -1000;
    if (cyc == 40000) begin
      n_fail++;
      summarize();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    axr(REG_STATUS);
    chk("reset status", 32'h0000fc00, rd);
    axr(REG_DELAY);
    chk("reset delay", {24'h0, DELAY_RESET}, rd);
    axw(REG_DELAY, 32'h0);
    axr(REG_DELAY);
    chk("delay zero ignored", {24'h0, DELAY_RESET}, rd);
    axr(8'h14);
    chk("bad read data", 32'h0, rd);
    chk("bad read resp", RESP_SLVERR, rs);
    axw(8'h14, 32'h0);
    chk("bad write resp", RESP_SLVERR, rs);
    for (int i = 0; i < 6; i++) begin
      axw(REG_CTRL, {30'h0, tab[i][7], 1'b0});
      axw(REG_WORD, {25'h0, tab[i][6:0]});
      axr(REG_STATUS);
      chk("print allowed", prints(tab[i][6:0], tab[i][7]), rd[16]);
      if (!prints(tab[i][6:0], tab[i][7])) begin
        axw(REG_GO, 32'h1);
        axr(REG_STATUS);
        chk("go refused", 0, rd[0]);
      end
    end
    axw(REG_CTRL, 32'h0);
    for (int k = 0; k < 5; k++) begin
      lf = nx(lf);
      lo = 7'h21 + 7'(lf[15:0] % 16'h3f);
      hi = 7'h21 + 7'(lf[31:16] % 16'h3f);
      if (k == 3) lo = 7'h61 + 7'(lf[7:0] % 8'h1a);
      rom <= lf[7:0] | 8'h01;
      view_en <= (k != 4);
      axw(REG_WORD, {17'h0, hi, 1'b0, lo});
      chk("rom addr", lo, rom_addr);
      run_char(lo, 1'b1);
      run_char(hi, 1'b0);
    end
    // Abort in mid-character with a second go pending
    axw(REG_WORD, 32'h00004141);
    axw(REG_GO, 32'h1);
    repeat (150) @(posedge clk);
    axw(REG_GO, 32'h1);
    axw(REG_CTRL, 32'h1);
    axr(REG_STATUS);
    chk("init status", 32'h0000fc00, rd & 32'h0000ffb7);
    summarize();
  end
endmodule
